// [dac_pipe_defines.vh]
// Purpose: Constants for the segmented converter input pipeline.
// Assumes: Included by bare name from the pipeline top only.
// Notes: Widths and split points of the sample word.
`ifndef DAC_PIPE_DEFINES_VH
`define DAC_PIPE_DEFINES_VH
`define SAMPLE_WIDTH 10
`define UPPER_WIDTH 6
`define LOWER_WIDTH 4
`define UPPER_LINES 64
`define LOWER_LINES 16
`define UPPER_LSB 4
`define BUF_DEPTH 2
`endif

// [word_buffer.v]
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: One clock, synchronous active-high reset.
// Notes: Full and empty are honest; a stalled drain fills it.
`timescale 1ns/1ns
module word_buffer #(
  parameter WIDTH = 10
) (
  // Clock and reset.
  input wire clk_sys,
  input wire reset,
  // Filling side.
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side.
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] slot0;
  reg [WIDTH-1:0] slot1;
  reg [1:0] count;
  wire push;
  wire pop;

  // Handshakes follow the fill count.
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = slot0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Slot 0 is the head; slot 1 holds the second word.
  always @(posedge clk_sys) begin
    if (reset) begin
      count <= 2'h0;
      slot0 <= {WIDTH{1'b0}};
      slot1 <= {WIDTH{1'b0}};
    end else begin
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
      if (pop) begin
        if (count == 2'h2) begin
          slot0 <= slot1;
        end else if (push) begin
          slot0 <= in_data;
        end
        if (push && count == 2'h2) begin
          slot1 <= in_data;
        end
      end else if (push) begin
        if (count == 2'h0) begin
          slot0 <= in_data;
        end else begin
          slot1 <= in_data;
        end
      end
    end
  end
endmodule

// [segmented_dac_input_pipeline.v]
// Purpose: Digital front end of a 10-bit segmented current-steering converter.
// Assumes: Sample source is on clk_sys; power_down_pin comes from a pin.
// Notes: Current outputs are modelled as unit-element counts summed over both segments.
`timescale 1ns/1ns
`include "dac_pipe_defines.vh"
// What this block does
// - Capture the sample word on a rising clock edge while sample_valid is high, ignore data otherwise.
// - Sample is ten bits, line 0 least significant, line 9 most.
// - Power-down is active high and has no pull-down; tie it low when unused.
// - Data passes an input stage and master-slave latch before decoding.
// - Split into six upper and four lower bits, each its own array.
// - Decode upper bits to 64 thermometer lines, lower bits to 16.
// - Register decoder outputs in a second latch bank driving the switches.
// - All ones gives full scale on true output; all zeros the reverse.
// - True output level never decreases as the input code increases.
// - While powered down both current outputs are forced to zero.
module segmented_dac_input_pipeline #(
  parameter SAMPLE_WIDTH = `SAMPLE_WIDTH
) (
  // Clock and reset.
  input wire clk_sys,
  input wire reset,
  // Sample source.
  input wire [`SAMPLE_WIDTH-1:0] sample_data_lines,
  input wire sample_valid,
  output wire sample_ready,
  // Power-down pin, one when sleeping; tie low when unused.
  input wire power_down_pin,
  // Switch select lines after the second latch bank.
  output reg [`UPPER_LINES-1:0] upper_select,
  output reg [`LOWER_LINES-1:0] lower_select,
  // Unit currents on each output, in LSB steps.
  output reg [`SAMPLE_WIDTH-1:0] true_current_output,
  output reg [`SAMPLE_WIDTH-1:0] complementary_current_output,
  output reg output_active
);
  reg pd_sync1;
  reg pd_sync2;
  reg [`SAMPLE_WIDTH-1:0] stage1_word;
  reg stage1_valid;
  wire buf_valid;
  wire [`SAMPLE_WIDTH-1:0] buf_word;
  wire [`UPPER_WIDTH-1:0] upper_code;
  wire [`LOWER_WIDTH-1:0] lower_code;
  reg [`UPPER_LINES-1:0] next_upper;
  reg [`LOWER_LINES-1:0] next_lower;
  reg [`SAMPLE_WIDTH-1:0] next_true;
  integer i;

  // Power-down pin is synchronised; reset state is awake, as a pin tied low.
  always @(posedge clk_sys) begin
    if (reset) begin
      pd_sync1 <= 1'b0;
      pd_sync2 <= 1'b0;
    end else begin
      pd_sync1 <= power_down_pin;
      pd_sync2 <= pd_sync1;
    end
  end

  // Input buffer stage; its drain is always ready, so it never holds more than one word.
  word_buffer #(
    .WIDTH(`SAMPLE_WIDTH)
  ) input_buffer (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_data_lines),
    .out_valid(buf_valid),
    .out_ready(1'b1),
    .out_data(buf_word)
  );

  // First latch bank takes the word only on a rising edge.
  always @(posedge clk_sys) begin
    if (reset) begin
      stage1_word <= {`SAMPLE_WIDTH{1'b0}};
      stage1_valid <= 1'b0;
    end else if (buf_valid) begin
      stage1_word <= buf_word;
      stage1_valid <= 1'b1;
    end
  end

  // Bit 0 is least significant; the top six bits form the upper segment.
  assign upper_code = stage1_word[`SAMPLE_WIDTH-1:`UPPER_LSB];
  assign lower_code = stage1_word[`UPPER_LSB-1:0];

  // Thermometer decoders: line k on when the segment code exceeds k.
  always @* begin
    next_upper = {`UPPER_LINES{1'b0}};
    next_lower = {`LOWER_LINES{1'b0}};
    for (i = 0; i < `UPPER_LINES; i = i + 1) begin
      next_upper[i] = ({26'h0, upper_code} > i);
    end
    for (i = 0; i < `LOWER_LINES; i = i + 1) begin
      next_lower[i] = ({28'h0, lower_code} > i);
    end
  end

  // Upper elements weigh sixteen units, lower ones one unit each.
  always @* begin
    next_true = {upper_code, lower_code};
  end

  // Second latch bank drives the switches and the output currents.
  always @(posedge clk_sys) begin
    if (reset) begin
      upper_select <= {`UPPER_LINES{1'b0}};
      lower_select <= {`LOWER_LINES{1'b0}};
      true_current_output <= {`SAMPLE_WIDTH{1'b0}};
      complementary_current_output <= {`SAMPLE_WIDTH{1'b0}};
      output_active <= 1'b0;
    end else if (pd_sync2) begin
      // Sleep forces both outputs to zero whatever the data.
      upper_select <= {`UPPER_LINES{1'b0}};
      lower_select <= {`LOWER_LINES{1'b0}};
      true_current_output <= {`SAMPLE_WIDTH{1'b0}};
      complementary_current_output <= {`SAMPLE_WIDTH{1'b0}};
      output_active <= 1'b0;
    end else begin
      upper_select <= next_upper;
      lower_select <= next_lower;
      true_current_output <= next_true;
      complementary_current_output <= ~next_true; // Complement sums to full scale.
      output_active <= stage1_valid;
    end
  end
endmodule

// [dac_pipe_chk_sva.sv]
// Purpose: Port checks. Assumes: Bound to the pipeline top. Notes: Words show three edges on.
`timescale 1ns/1ns
module dac_pipe_chk (
  // Watched ports.
  input wire clk_sys, input wire reset, input wire sample_valid, input wire sample_ready,
  input wire [9:0] sample_data_lines, input wire power_down_pin, input wire output_active,
  input wire [63:0] upper_select, input wire [15:0] lower_select,
  input wire [9:0] true_current_output, input wire [9:0] complementary_current_output);
  // Short aliases keep each check on few lines.
  wire [9:0] t = true_current_output, c = complementary_current_output;
  wire pd = power_down_pin, act = output_active, tk = sample_valid && sample_ready;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_sum_full: assert property (act |-> t + c == 10'h3FF) else $error("Bad sum.");
  a_ready_high: assert property (sample_ready) else $error("Not ready.");
  a_upper_therm: assert property (act |-> upper_select == (64'h1 << t[9:4]) - 64'h1)
    else $error("Bad upper lines.");
  a_lower_therm: assert property (act |-> lower_select == (16'h1 << t[3:0]) - 16'h1)
    else $error("Bad lower lines.");
  a_word_latency: assert property ((tk && !pd && !$past(pd) && !$past(pd, 2)) ##1 !pd [*2]
    |=> t == $past(sample_data_lines, 3) && act) else $error("Late word.");
  a_idle_hold: assert property ((!sample_valid && !pd) [*6] |-> $stable(t))
    else $error("Idle data taken.");
  a_sleep_zero: assert property (pd [*4] |=> t == 10'h000 && c == 10'h000 && !act)
    else $error("Awake in sleep.");
  a_code_monotone: assert property (act && $past(act) && t > $past(t)
    |-> upper_select >= $past(upper_select)) else $error("Not monotonic.");
  // Main scenarios reached.
  cover property (tk);
  cover property (pd [*4]);
  cover property (act && t == 10'h3FF);
endmodule
bind segmented_dac_input_pipeline dac_pipe_chk u_chk (.*);

// [sample_source.sv]
// Purpose: Sample source model. Assumes: Bench sets offer and word. Notes: Idle lines toggle.
`timescale 1ns/1ns
module sample_source (
  // Bench side, then the block's input pins.
  input wire clk_sys, input wire offer, input wire [9:0] word, input wire power_down_pin,
  output wire sample_valid, output wire [9:0] sample_data_lines);
  reg [9:0] noise = 10'h155;
  // Unoffered lines change each cycle but stand still in sleep.
  always @(negedge clk_sys) if (!power_down_pin) noise <= ~noise;
  // Line 0 carries the least significant bit.
  assign sample_valid = offer;
  assign sample_data_lines = offer ? word : noise;
endmodule

// [segmented_dac_input_pipeline_tb.sv]
// Purpose: Pipeline bench. Assumes: Source model and checker. Notes: Drives on falling edges.
`timescale 1ns/1ns
module segmented_dac_input_pipeline_tb;
  reg clk_sys = 0, reset = 1, power_down_pin = 0, offer = 0;
  reg [9:0] word = 10'h000;
  wire [9:0] sample_data_lines, true_current_output, complementary_current_output;
  wire [63:0] upper_select;
  wire [15:0] lower_select;
  wire sample_valid, sample_ready, output_active;
  integer err_count = 0, tests_run = 0, seed = 24525, i;
  // Clock of fifty nanoseconds.
  always #25 clk_sys = ~clk_sys;
  sample_source u_src (.*);
  segmented_dac_input_pipeline u_dut (.*);
  // Compares a seen value with the expected one.
  task check(input [63:0] seen, input [63:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("mismatch at %0t: %h not %h", $time, seen, exp);
      end
    end
  endtask
  // Offers one word and checks it once settled.
  task send(input [9:0] w);
    begin
      word = w;
      offer = 1;
      @(negedge clk_sys);
      offer = 0;
      repeat (4) @(negedge clk_sys);
      check(true_current_output, w);
      check(upper_select, (64'h1 << w[9:4]) - 1);
      check(lower_select, (64'h1 << w[3:0]) - 1);
      check(complementary_current_output, 10'h3FF - w);
      check(output_active, 1'b1);
    end
  endtask
  // Prints the counts and the verdict, then ends.
  task summarize;
    begin
      $display("tests %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Watchdog for a hung run.
  initial begin
    #150000;
    err_count = err_count + 1;
    summarize;
  end
  // Corner and random codes, an ascending sweep, then sleep.
  initial begin
    repeat (16) @(negedge clk_sys);
    reset = 0;
    for (i = 0; i < 30; i = i + 1)
      send(i < 4 ? {10{i[0]}} ^ {i[1], 9'h000} : $random(seed));
    $display("codes done");
    offer = 1;
    for (i = 0; i < 1024; i = i + 1) begin
      word = i;
      @(negedge clk_sys);
    end
    offer = 0;
    repeat (4) @(negedge clk_sys);
    check(true_current_output, 10'h3FF);
    $display("sweep done");
    power_down_pin = 1;
    offer = 1;
    repeat (6) @(negedge clk_sys);
    offer = 0;
    check({output_active, true_current_output, complementary_current_output}, 0);
    power_down_pin = 0;
    repeat (6) @(negedge clk_sys);
    send(10'h0C3);
    $display("sleep done");
    summarize;
  end
endmodule
